// file: bench/sxt_line_model.sv
// remote serial device: frame sender, frame catcher, clock pin sampler
`timescale 1ns/1ps
`default_nettype none
module sxt_line_model (
    // line side
    input wire logic clk_i,
    input wire logic tx_i,
    input wire logic sclk_i,
    output logic rx_o
);
    int bit_len = 16;
    int nbits = 8;
    int got_cnt = 0;
    int low_cnt = 0;
    int low_run = 0;
    int edge_cnt = 0;
    logic [8:0] got_word = '0;
    logic [7:0] sync_sr = '0;
    initial rx_o = 1'b1;
    // catch frames on tx, sampling each bit mid way
    initial begin
        forever begin
            @(negedge tx_i);
            got_word = '0;
            repeat (bit_len / 2) @(posedge clk_i);
            for (int i = 0; i < nbits; i++) begin
                repeat (bit_len) @(posedge clk_i);
                got_word[i] = tx_i;
            end
            got_cnt++;
        end
    end
    always @(posedge clk_i) begin
        if (!tx_i) begin
            low_cnt <= low_cnt + 1;
        end else begin
            if (low_cnt != 0) begin
                low_run <= low_cnt;
            end
            low_cnt <= 0;
        end
    end
    always @(posedge sclk_i) begin
        edge_cnt <= edge_cnt + 1;
        sync_sr <= {tx_i, sync_sr[7:1]};
    end
    // each bit is held whole, so it stays stable around any sampling edge
    task automatic send(input logic [8:0] w, input logic stop, input int gap);
        rx_o <= 1'b0;
        repeat (bit_len) @(posedge clk_i);
        for (int i = 0; i < nbits; i++) begin
            rx_o <= w[i];
            repeat (bit_len) @(posedge clk_i);
        end
        rx_o <= stop;
        repeat (bit_len) @(posedge clk_i);
        rx_o <= 1'b1;
        repeat (gap) @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// file: bench/sxt_top_asserts.sv
// bus, line and clock pin checks of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module sxt_chk
    import sxt_pkg::*;
(
    // clock, reset and bus
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    input wire logic [31:0] AVS_READDATA_O,
    input wire logic AVS_WAITREQUEST_O,
    // line
    input wire logic RX_I,
    input wire logic TX_O,
    input wire logic SCLK_O
);
    logic wr_ok;
    logic tx_r, tx_nxt;
    logic [15:0] baud_r, baud_nxt;
    logic [SXT_CTL_W-1:0] ctl_r, ctl_nxt;
    logic [19:0] run_r, run_nxt, pre_r, pre_nxt;
    assign wr_ok = AVS_WRITE_I && !AVS_WAITREQUEST_O;
    always_comb begin
        tx_nxt = TX_O;
        baud_nxt = baud_r;
        ctl_nxt = ctl_r;
        run_nxt = (TX_O != tx_r) ? 20'h0_0001 : run_r + 20'h0_0001;
        pre_nxt = (pre_r != 20'h0_0000) ? pre_r - 20'h0_0001 : pre_r;
        if (wr_ok && AVS_ADDRESS_I == SXT_OFS_BAUD) begin
            baud_nxt = AVS_WRITEDATA_I[15:0];
        end
        if (wr_ok && AVS_ADDRESS_I == SXT_OFS_CTRL) begin
            ctl_nxt = AVS_WRITEDATA_I[SXT_CTL_W-1:0];
            // ten bits of clocks, less 16 clocks of slack for tick phase
            if (AVS_WRITEDATA_I[SXT_CTL_TXEN] && !ctl_r[SXT_CTL_TXEN] && baud_r != 16'h0000) begin
                pre_nxt = {4'h0, baud_r} * 20'h0_000A - 20'h0_0010;
            end
        end
    end
    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            tx_r <= 1'b1;
            baud_r <= 16'h0000;
            ctl_r <= '0;
            run_r <= 20'h0_1000;
            pre_r <= 20'h0_0000;
        end else begin
            tx_r <= tx_nxt;
            baud_r <= baud_nxt;
            ctl_r <= ctl_nxt;
            run_r <= run_nxt;
            pre_r <= pre_nxt;
        end
    end
    default clocking @(posedge CLK_I);
    endclocking
    default disable iff (!ARST_N_I);
    a_wait_answer: assert property (
        (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
        else $error("bus request not answered on the next cycle");
    a_wait_single: assert property (!AVS_WAITREQUEST_O |=> AVS_WAITREQUEST_O)
        else $error("waitrequest low for more than one cycle");
    a_unmapped_zero: assert property (
        AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I[1:0] != 2'h0 |-> AVS_READDATA_O == 0)
        else $error("unmapped read returned nonzero");
    a_rdata_hold: assert property (
        $changed(AVS_READDATA_O) |-> AVS_READ_I && !AVS_WAITREQUEST_O)
        else $error("read data changed outside a read answer");
    a_tx_reset_idle: assert property ($rose(ARST_N_I) |-> (TX_O && !SCLK_O) [*8])
        else $error("line not idle after reset");
    a_tx_bit_run: assert property (TX_O != tx_r |-> run_r >= 20'h0_0010)
        else $error("tx level held for less than one bit");
    a_preamble_high: assert property (pre_r != 20'h0_0000 |-> TX_O)
        else $error("tx left idle during the enable preamble");
    a_sclk_parked: assert property (
        !ctl_r[SXT_CTL_SYNC_CLOCK_ENABLE] && $stable(ctl_r) |-> SCLK_O == ctl_r[SXT_CTL_CLOCK_POLARITY_SEL])
        else $error("clock pin moved with clock output off");
    c_read_done: cover property (AVS_READ_I && !AVS_WAITREQUEST_O);
    c_preamble: cover property (pre_r == 20'h0_0001);
    c_sclk_pulse: cover property ($rose(SCLK_O) && ctl_r[SXT_CTL_SYNC_CLOCK_ENABLE]);
endmodule
bind sxt_top sxt_chk i_chk (
    .CLK_I(CLK_I), .ARST_N_I(ARST_N_I), .AVS_ADDRESS_I(AVS_ADDRESS_I),
    .AVS_READ_I(AVS_READ_I), .AVS_WRITE_I(AVS_WRITE_I), .AVS_WRITEDATA_I(AVS_WRITEDATA_I),
    .AVS_BYTEENABLE_I(AVS_BYTEENABLE_I), .AVS_READDATA_O(AVS_READDATA_O),
    .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O), .RX_I(RX_I), .TX_O(TX_O), .SCLK_O(SCLK_O));
`default_nettype wire

// file: bench/testbench.sv
// self-checking bench of the serial transceiver
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sxt_pkg::*;
    logic clk, arst_n, rd_en, wr_en, wait_req, rx, tx, sclk;
    logic [3:0] addr;
    logic [31:0] wdata, rdata, q;
    int failures = 0;
    int comparisons = 0;
    int n, e;
    logic [15:0] cfg [6] = '{16'h0003, 16'h000B, 16'h001B, 16'h0007, 16'h000F, 16'h0023};
    logic [8:0] dat [6] = '{9'h0A5, 9'h031, 9'h0B1, 9'h1A5, 9'h013, 9'h05A};
    logic [8:0] exp_w [6] = '{9'h0A5, 9'h0B1, 9'h031, 9'h1A5, 9'h113, 9'h05A};
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    sxt_top i_dut (.CLK_I(clk), .ARST_N_I(arst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd_en),
        .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(4'hF),
        .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(wait_req), .RX_I(rx), .TX_O(tx),
        .SCLK_O(sclk));
    sxt_line_model i_line (.clk_i(clk), .tx_i(tx), .sclk_i(sclk), .rx_o(rx));
    task automatic test_done();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] x);
        comparisons++;
        if (g !== x) begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, g, x);
        end
    endtask
    task automatic tmo(input int k);
        if (k >= 4000) begin
            failures++;
            $display("unexpected at %0t: wait ran out", $time);
            test_done();
        end
    endtask
    // request held until the edge that sees waitrequest low
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        int k;
        k = 0;
        addr <= a;
        rd_en <= !w;
        wr_en <= w;
        wdata <= d;
        @(posedge clk);
        while (wait_req !== 1'b0 && k < 4000) begin
            @(posedge clk);
            k++;
        end
        tmo(k);
        q = rdata;
        rd_en <= 1'b0;
        wr_en <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] x, input logic [31:0] m);
        bus(1'b0, a, 32'h0000_0000);
        chk(q & m, x);
    endtask
    task automatic wait_low();
        n = 0;
        while (tx !== 1'b0 && n < 4000) begin
            @(posedge clk);
            n++;
        end
        tmo(n);
    endtask
    // frame caught, then room for two stop bits
    task automatic wait_rx();
        int c, k;
        c = i_line.got_cnt;
        k = 0;
        while (i_line.got_cnt == c && k < 4000) begin
            @(posedge clk);
            k++;
        end
        tmo(k);
        repeat (48) @(posedge clk);
    endtask
    task automatic wait_rxne();
        int k;
        k = 0;
        q = 32'h0000_0000;
        while (q[SXT_ST_RXNE] !== 1'b1 && k < 4000) begin
            bus(1'b0, SXT_OFS_STATUS, 32'h0000_0000);
            k++;
        end
        tmo(k);
    endtask
    initial begin
        arst_n = 1'b0;
        addr = 4'h0;
        rd_en = 1'b0;
        wr_en = 1'b0;
        wdata = 32'h0000_0000;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        rd(SXT_OFS_STATUS, 32'h0000_0003, 32'h0000_003F);
        rd(SXT_OFS_CTRL, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b1, 4'h2, 32'hFFFF_FFFF);
        rd(4'h2, 32'h0000_0000, 32'hFFFF_FFFF);
        bus(1'b1, SXT_OFS_BAUD, 32'h0000_0010);
        rd(SXT_OFS_BAUD, 32'h0000_0010, 32'h0000_FFFF);
        bus(1'b1, SXT_OFS_CTRL, 32'h0000_0003);
        bus(1'b1, SXT_OFS_DATA, 32'h0000_00A5);
        wait_low();
        chk(32'(n >= 150), 32'h0000_0001);
        wait_rx();
        chk({23'h0, i_line.got_word}, 32'h0000_00A5);
        for (int i = 0; i < 6; i++) begin
            bus(1'b1, SXT_OFS_CTRL, {16'h0000, cfg[i]});
            i_line.nbits = cfg[i][SXT_CTL_WLEN9] ? 9 : 8;
            bus(1'b1, SXT_OFS_DATA, {23'h0, dat[i]});
            wait_rx();
            chk({23'h0, i_line.got_word}, {23'h0, exp_w[i]});
        end
        bus(1'b1, SXT_OFS_CTRL, 32'h0000_0043);
        wait_low();
        bus(1'b1, SXT_OFS_CTRL, 32'h0000_0003);
        repeat (400) @(posedge clk);
        chk(32'(i_line.low_run), 32'h0000_00A0);
        bus(1'b1, SXT_OFS_BAUD, 32'h0000_0018);
        i_line.bit_len = 24;
        bus(1'b1, SXT_OFS_DATA, 32'h0000_0000);
        wait_rx();
        chk(32'(i_line.low_run), 32'h0000_00D8);
        bus(1'b1, SXT_OFS_BAUD, 32'h0000_0010);
        i_line.bit_len = 16;
        i_line.send(9'h03C, 1'b1, 0);
        wait_rxne();
        rd(SXT_OFS_DATA, 32'h0000_003C, 32'h0000_01FF);
        rd(SXT_OFS_STATUS, 32'h0000_0000, 32'h0000_003C);
        i_line.send(9'h0F0, 1'b0, 64);
        wait_rxne();
        chk(q & 32'h0000_0008, 32'h0000_0008);
        bus(1'b1, SXT_OFS_CTRL, 32'h0000_0000);
        for (int i = 0; i < 2; i++) begin
            bus(1'b1, SXT_OFS_CTRL, i == 0 ? 32'h0000_0480 : 32'h0000_0080);
            e = i_line.edge_cnt;
            bus(1'b1, SXT_OFS_CTRL, i == 0 ? 32'h0000_0483 : 32'h0000_0083);
            bus(1'b1, SXT_OFS_DATA, 32'h0000_00B4);
            wait_low();
            // clock controls must stay put while a frame is out
            bus(1'b1, SXT_OFS_CTRL, i == 0 ? 32'h0000_0482 : 32'h0000_0082);
            wait_rx();
            chk({23'h0, i_line.got_word}, 32'h0000_00B4);
            chk(32'(i_line.edge_cnt - e), 32'(8 - i));
            // idle-high rx gives all ones in sync receive
            rd(SXT_OFS_DATA, 32'h0000_00FF, 32'h0000_01FF);
            bus(1'b1, SXT_OFS_CTRL, 32'h0000_0000);
            if (i == 0) begin
                chk({24'h0, i_line.sync_sr}, 32'h0000_00B4);
            end
        end
        bus(1'b1, SXT_OFS_CTRL, 32'h0000_0180);
        repeat (4) @(posedge clk);
        chk({31'h0, sclk}, 32'h0000_0001);
        test_done();
    end
endmodule
`default_nettype wire

// file: src/sxt_pkg.sv
// constants, register map and types of the serial transceiver
package sxt_pkg;
    // register byte offsets
    localparam logic [3:0] SXT_OFS_STATUS = 4'h0;
    localparam logic [3:0] SXT_OFS_DATA = 4'h4;
    localparam logic [3:0] SXT_OFS_BAUD = 4'h8;
    localparam logic [3:0] SXT_OFS_CTRL = 4'hC;
    // control register field positions
    localparam int SXT_CTL_TXEN = 0;
    localparam int SXT_CTL_RXEN = 1;
    localparam int SXT_CTL_WLEN9 = 2;
    localparam int SXT_CTL_PAREN = 3;
    localparam int SXT_CTL_PODD = 4;
    localparam int SXT_CTL_STOP2 = 5;
    localparam int SXT_CTL_BRK = 6;
    localparam int SXT_CTL_SYNC_CLOCK_ENABLE = 7;
    localparam int SXT_CTL_CLOCK_POLARITY_SEL = 8;
    localparam int SXT_CTL_CLOCK_PHASE_SEL = 9;
    localparam int SXT_CTL_LAST_BIT_CLOCK_PULSE = 10;
    localparam int SXT_CTL_SMARTCARD_ENABLE = 11;
    localparam int SXT_CTL_HALF_DUPLEX_SELECT = 12;
    localparam int SXT_CTL_INFRARED_ENABLE = 13;
    localparam int SXT_CTL_W = 14;
    // status register field positions
    localparam int SXT_ST_TXE = 0;
    localparam int SXT_ST_TC = 1;
    localparam int SXT_ST_RXNE = 2;
    localparam int SXT_ST_FE = 3;
    localparam int SXT_ST_PE = 4;
    localparam int SXT_ST_ORE = 5;
    // reset values
    localparam logic [15:0] SXT_BAUD_RST = 16'h0000;
    localparam logic [SXT_CTL_W-1:0] SXT_CTL_RST = 14'h0000;
    // oversampling and frame figures
    localparam int SXT_OVS = 16;
    localparam int SXT_IDLE_BITS_8 = 10;
    localparam int SXT_IDLE_BITS_9 = 11;
    localparam logic [3:0] SXT_MID_SAMPLE = 4'h7;
    localparam logic [3:0] SXT_LAST_TICK = 4'hF;
    localparam logic [3:0] SXT_HALF_TICK = 4'h8;

    typedef enum {SXT_TX_IDLE, SXT_TX_PREAMBLE, SXT_TX_START, SXT_TX_DATA,
        SXT_TX_STOP, SXT_TX_BREAK} sxt_tx_state_type;
    typedef enum {SXT_RX_IDLE, SXT_RX_START, SXT_RX_DATA, SXT_RX_STOP} sxt_rx_state_type;
endpackage

// file: src/sxt_top.sv
// serial transceiver with fractional baud generator and synchronous clock master
// Overview of operation
// - with tx_enable set, shift data out on tx and clock on serial_clock_pin.
// - frame starts with low start bit, data sent lsb first.
// - word length selects 8 or 9 data bits; one or two stop bits.
// - with parity enabled, top data position carries the parity bit.
// - setting tx_enable first sends idle frame of 10 or 11 high bits.
// - break holds line low 10 or 11 bit times, then one stop bit; the code sends one or two stop bits, per stop2.
// - bit rate is clock divided by sixteen times baud_divisor.
// - baud_divisor is integer field plus fraction in sixteenths from baud_rate_reg.
// - generator reaches bit rates up to 3 Mbps.
// - receiver tolerates at least 3 percent combined deviation.
// - synchronous mode is clock master only; serial_clock_pin is output.
// - clock pulses only during data bits, never start, stop or idle.
// - last_bit_clock_pulse decides pulse on final data bit.
// - clock_polarity_sel sets idle level, clock_phase_sel sets data edge.
// - synchronous receive samples rx at own clock edges only; the code samples the last data bit even when no pulse goes out for it.
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module sxt_top
    import sxt_pkg::*;
(
    // clock and reset
    input wire logic CLK_I,
    input wire logic ARST_N_I,
    // avalon-mm slave
    input wire logic [3:0] AVS_ADDRESS_I,
    input wire logic AVS_READ_I,
    input wire logic AVS_WRITE_I,
    input wire logic [31:0] AVS_WRITEDATA_I,
    input wire logic [3:0] AVS_BYTEENABLE_I,
    output logic [31:0] AVS_READDATA_O,
    output logic AVS_WAITREQUEST_O,
    // serial line
    input wire logic RX_I,
    output logic TX_O,
    output logic SCLK_O
);
    logic [15:0] baud_r, baud_nxt;
    logic [SXT_CTL_W-1:0] ctl_r, ctl_nxt;
    logic [8:0] txbuf_r, txbuf_nxt;
    logic txe_r, txe_nxt, tc_r, tc_nxt;
    logic [8:0] rxbuf_r, rxbuf_nxt;
    logic rxne_r, rxne_nxt, fe_r, fe_nxt, pe_r, pe_nxt, ore_r, ore_nxt;
    logic [31:0] rd_r, rd_nxt;
    logic ack_r, ack_nxt;
    logic [15:0] acc_r, acc_nxt;
    logic tick_r, tick_nxt;
    sxt_tx_state_type tst_r, tst_nxt;
    logic [3:0] tph_r, tph_nxt;
    logic [3:0] tbit_r, tbit_nxt;
    logic [8:0] tsh_r, tsh_nxt;
    logic txen_act_r, txen_act_nxt;
    logic tx_r, tx_nxt, sclk_r, sclk_nxt;
    sxt_rx_state_type rst_r, rst_nxt;
    logic [3:0] rph_r, rph_nxt;
    logic [3:0] rbit_r, rbit_nxt;
    logic [8:0] rsh_r, rsh_nxt;
    logic rx_prev_r, rx_prev_nxt;

    logic req, wr, rd, w9, sync;
    logic [3:0] nbits;
    logic [31:0] wmask;
    logic [8:0] txword;
    logic [15:0] ctl_wide;
    logic sclk_pulse, rx_edge;

    assign req = (AVS_READ_I | AVS_WRITE_I) & ~ack_r;
    assign wr = AVS_WRITE_I & ~ack_r;
    assign rd = AVS_READ_I & ~ack_r;
    assign w9 = ctl_r[SXT_CTL_WLEN9];
    assign sync = ctl_r[SXT_CTL_SYNC_CLOCK_ENABLE];
    assign nbits = w9 ? 4'd9 : 4'd8;
    assign wmask = {{8{AVS_BYTEENABLE_I[3]}}, {8{AVS_BYTEENABLE_I[2]}},
        {8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
    assign ctl_wide = {2'b00, ctl_r};

    // register file and bus slave: one wait cycle, answer on second edge
    always_comb begin
        baud_nxt = baud_r;
        ctl_nxt = ctl_r;
        rd_nxt = rd_r;
        ack_nxt = 1'b0;
        if (req) begin
            ack_nxt = 1'b1;
        end
        if (wr) begin
            case (AVS_ADDRESS_I)
                SXT_OFS_BAUD: begin
                    baud_nxt = (baud_r & ~wmask[15:0]) | (AVS_WRITEDATA_I[15:0] & wmask[15:0]);
                end
                SXT_OFS_CTRL: begin
                    ctl_nxt = (ctl_r & ~wmask[SXT_CTL_W-1:0])
                        | (AVS_WRITEDATA_I[SXT_CTL_W-1:0] & wmask[SXT_CTL_W-1:0]);
                end
                default: begin
                end
            endcase
        end
        if (rd) begin
            case (AVS_ADDRESS_I)
                SXT_OFS_STATUS: rd_nxt = {26'h000_0000, ore_r, pe_r, fe_r, rxne_r, tc_r, txe_r};
                SXT_OFS_DATA: rd_nxt = {23'h00_0000, rxbuf_r};
                SXT_OFS_BAUD: rd_nxt = {16'h0000, baud_r};
                SXT_OFS_CTRL: rd_nxt = {16'h0000, ctl_wide};
                default: rd_nxt = 32'h0000_0000;
            endcase
        end
    end

    // fractional baud tick: accumulator adds 16 sixteenths each clock, a tick at each wrap of baud_divisor
    always_comb begin
        acc_nxt = acc_r + 16'h0010;
        tick_nxt = 1'b0;
        if (baud_r == 16'h0000) begin
            acc_nxt = 16'h0000;
        end else if (acc_nxt >= baud_r) begin
            acc_nxt = acc_nxt - baud_r;
            tick_nxt = 1'b1;
        end
    end

    // transmit word with parity in the top data position
    always_comb begin
        txword = txbuf_r;
        if (ctl_r[SXT_CTL_PAREN]) begin
            if (w9) begin
                txword[8] = ^txbuf_r[7:0] ^ ctl_r[SXT_CTL_PODD];
            end else begin
                txword[7] = ^txbuf_r[6:0] ^ ctl_r[SXT_CTL_PODD];
            end
        end
        if (!w9) begin
            txword[8] = 1'b1;
        end
    end

    // clock pulse window: data bits only, last one per setting
    assign sclk_pulse = sync && tst_r == SXT_TX_DATA
        && (tbit_r != nbits - 4'd1 || ctl_r[SXT_CTL_LAST_BIT_CLOCK_PULSE]);

    // transmitter
    always_comb begin
        tst_nxt = tst_r;
        tph_nxt = tph_r;
        tbit_nxt = tbit_r;
        tsh_nxt = tsh_r;
        txbuf_nxt = txbuf_r;
        txe_nxt = txe_r;
        tc_nxt = tc_r;
        txen_act_nxt = txen_act_r;
        tx_nxt = tx_r;
        sclk_nxt = ctl_r[SXT_CTL_CLOCK_POLARITY_SEL];
        if (wr && AVS_ADDRESS_I == SXT_OFS_DATA && AVS_BYTEENABLE_I[0]) begin
            txbuf_nxt = {AVS_WRITEDATA_I[8] & AVS_BYTEENABLE_I[1], AVS_WRITEDATA_I[7:0]};
            txe_nxt = 1'b0;
            tc_nxt = 1'b0;
        end
        if (rd && AVS_ADDRESS_I == SXT_OFS_STATUS) begin
            tc_nxt = 1'b0;
        end
        if (sclk_pulse) begin
            // first half / second half of the bit gives the two edges
            sclk_nxt = ctl_r[SXT_CTL_CLOCK_POLARITY_SEL] ^ (ctl_r[SXT_CTL_CLOCK_PHASE_SEL] ? (tph_r < SXT_HALF_TICK)
                : (tph_r >= SXT_HALF_TICK));
        end
        if (tick_r) begin
            tph_nxt = tph_r + 4'd1;
            case (tst_r)
                SXT_TX_IDLE: begin
                    tph_nxt = 4'd0;
                    tx_nxt = 1'b1;
                    if (!ctl_r[SXT_CTL_TXEN]) begin
                        txen_act_nxt = 1'b0;
                    end else if (!txen_act_r) begin
                        txen_act_nxt = 1'b1;
                        tbit_nxt = 4'd0;
                        tst_nxt = SXT_TX_PREAMBLE;
                    end else if (ctl_r[SXT_CTL_BRK]) begin
                        tbit_nxt = 4'd0;
                        tx_nxt = 1'b0;
                        tst_nxt = SXT_TX_BREAK;
                    end else if (!txe_r) begin
                        tsh_nxt = txword;
                        txe_nxt = 1'b1;
                        tx_nxt = 1'b0;
                        tst_nxt = SXT_TX_START;
                    end
                end
                SXT_TX_PREAMBLE, SXT_TX_BREAK: begin
                    if (tph_r == SXT_LAST_TICK) begin
                        tbit_nxt = tbit_r + 4'd1;
                        if (tbit_r == (w9 ? 4'(SXT_IDLE_BITS_9 - 1) : 4'(SXT_IDLE_BITS_8 - 1))) begin
                            tbit_nxt = 4'd0;
                            tx_nxt = 1'b1;
                            if (tst_r == SXT_TX_BREAK) begin
                                tst_nxt = SXT_TX_STOP;
                            end else begin
                                tst_nxt = SXT_TX_IDLE;
                            end
                        end
                    end
                end
                SXT_TX_START: begin
                    if (tph_r == SXT_LAST_TICK) begin
                        tbit_nxt = 4'd0;
                        tx_nxt = tsh_r[0];
                        tst_nxt = SXT_TX_DATA;
                    end
                end
                SXT_TX_DATA: begin
                    if (tph_r == SXT_LAST_TICK) begin
                        tsh_nxt = {1'b1, tsh_r[8:1]};
                        tx_nxt = tsh_r[1];
                        tbit_nxt = tbit_r + 4'd1;
                        if (tbit_r == nbits - 4'd1) begin
                            tbit_nxt = 4'd0;
                            tx_nxt = 1'b1;
                            tst_nxt = SXT_TX_STOP;
                        end
                    end
                end
                SXT_TX_STOP: begin
                    if (tph_r == SXT_LAST_TICK) begin
                        tbit_nxt = tbit_r + 4'd1;
                        if (tbit_r == {3'b000, ctl_r[SXT_CTL_STOP2]}) begin
                            tbit_nxt = 4'd0;
                            tc_nxt = txe_r;
                            tst_nxt = SXT_TX_IDLE;
                        end
                    end
                end
                default: tst_nxt = SXT_TX_IDLE;
            endcase
        end
    end

    // receiver: async uses x16 oversampling, sync samples at own clock edge
    assign rx_edge = rx_prev_r & ~RX_I;
    always_comb begin
        rst_nxt = rst_r;
        rph_nxt = rph_r;
        rbit_nxt = rbit_r;
        rsh_nxt = rsh_r;
        rxbuf_nxt = rxbuf_r;
        rxne_nxt = rxne_r;
        fe_nxt = fe_r;
        pe_nxt = pe_r;
        ore_nxt = ore_r;
        rx_prev_nxt = rx_prev_r;
        if (rd && AVS_ADDRESS_I == SXT_OFS_DATA) begin
            rxne_nxt = 1'b0;
            fe_nxt = 1'b0;
            pe_nxt = 1'b0;
            ore_nxt = 1'b0;
        end
        if (!ctl_r[SXT_CTL_RXEN]) begin
            rst_nxt = SXT_RX_IDLE;
        end else if (sync) begin
            // sample on the data-valid clock edge, mid bit
            if (tick_r && tst_r == SXT_TX_DATA && tph_r == SXT_MID_SAMPLE) begin
                rsh_nxt = {RX_I, rsh_r[8:1]};
                if (tbit_r == nbits - 4'd1) begin
                    rxbuf_nxt = w9 ? {RX_I, rsh_r[8:1]} : {1'b0, RX_I, rsh_r[8:2]};
                    ore_nxt = rxne_r | ore_r;
                    rxne_nxt = 1'b1;
                end
            end
        end else if (tick_r) begin
            rx_prev_nxt = RX_I;
            rph_nxt = rph_r + 4'd1;
            case (rst_r)
                SXT_RX_IDLE: begin
                    if (rx_edge) begin
                        rph_nxt = 4'd0;
                        rst_nxt = SXT_RX_START;
                    end
                end
                SXT_RX_START: begin
                    if (rph_r == SXT_MID_SAMPLE) begin
                        // glitch rejected at mid start bit for deviation margin
                        rst_nxt = RX_I ? SXT_RX_IDLE : SXT_RX_DATA;
                        rph_nxt = 4'd0;
                        rbit_nxt = 4'd0;
                    end
                end
                SXT_RX_DATA: begin
                    if (rph_r == SXT_LAST_TICK) begin
                        rsh_nxt = w9 ? {RX_I, rsh_r[8:1]} : {1'b0, RX_I, rsh_r[7:1]};
                        rbit_nxt = rbit_r + 4'd1;
                        if (rbit_r == nbits - 4'd1) begin
                            rst_nxt = SXT_RX_STOP;
                        end
                    end
                end
                SXT_RX_STOP: begin
                    if (rph_r == SXT_LAST_TICK) begin
                        rxbuf_nxt = rsh_r;
                        fe_nxt = ~RX_I | fe_r;
                        pe_nxt = pe_r | (ctl_r[SXT_CTL_PAREN]
                            & ((^rsh_r) ^ ctl_r[SXT_CTL_PODD]));
                        ore_nxt = rxne_r | ore_r;
                        rxne_nxt = 1'b1;
                        rst_nxt = SXT_RX_IDLE;
                    end
                end
                default: rst_nxt = SXT_RX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            baud_r <= SXT_BAUD_RST;
            ctl_r <= SXT_CTL_RST;
            txbuf_r <= 9'h000;
            txe_r <= 1'b1;
            tc_r <= 1'b1;
            rxbuf_r <= 9'h000;
            rxne_r <= 1'b0;
            fe_r <= 1'b0;
            pe_r <= 1'b0;
            ore_r <= 1'b0;
            rd_r <= 32'h0000_0000;
            ack_r <= 1'b0;
            acc_r <= 16'h0000;
            tick_r <= 1'b0;
            tst_r <= SXT_TX_IDLE;
            tph_r <= 4'h0;
            tbit_r <= 4'h0;
            tsh_r <= 9'h1FF;
            txen_act_r <= 1'b0;
            tx_r <= 1'b1;
            sclk_r <= 1'b0;
            rst_r <= SXT_RX_IDLE;
            rph_r <= 4'h0;
            rbit_r <= 4'h0;
            rsh_r <= 9'h000;
            rx_prev_r <= 1'b1;
        end else begin
            baud_r <= baud_nxt;
            ctl_r <= ctl_nxt;
            txbuf_r <= txbuf_nxt;
            txe_r <= txe_nxt;
            tc_r <= tc_nxt;
            rxbuf_r <= rxbuf_nxt;
            rxne_r <= rxne_nxt;
            fe_r <= fe_nxt;
            pe_r <= pe_nxt;
            ore_r <= ore_nxt;
            rd_r <= rd_nxt;
            ack_r <= ack_nxt;
            acc_r <= acc_nxt;
            tick_r <= tick_nxt;
            tst_r <= tst_nxt;
            tph_r <= tph_nxt;
            tbit_r <= tbit_nxt;
            tsh_r <= tsh_nxt;
            txen_act_r <= txen_act_nxt;
            tx_r <= tx_nxt;
            sclk_r <= sclk_nxt;
            rst_r <= rst_nxt;
            rph_r <= rph_nxt;
            rbit_r <= rbit_nxt;
            rsh_r <= rsh_nxt;
            rx_prev_r <= rx_prev_nxt;
        end
    end

    assign AVS_READDATA_O = rd_r;
    assign AVS_WAITREQUEST_O = ~ack_r;
    assign TX_O = tx_r;
    assign SCLK_O = sclk_r;
endmodule
`default_nettype wire
